// ### fetch_front_pkg.sv
// constants, types and state for the instruction fetch front end
`default_nettype none
package fetch_front_pkg;
	localparam int         ENTRIES      = 4;
	localparam int         WAYS         = 2;
	localparam int         LINES        = 16;
	localparam int         BLK_WORDS    = 4;
	localparam int         BLK_WORDS_CO = 2;
	localparam int         ATAG_W       = 26;
	localparam int         SPACE_W      = 3;
	localparam logic [3:0] CFG_OFF      = 4'h0;
	localparam logic [3:0] STAT_OFF     = 4'h4;
	localparam int         CFG_CO_BIT   = 0;
	localparam int         CFG_CD_BIT   = 1;
	localparam logic [1:0] CFG_RST      = 2'h0;
	localparam logic [31:0] PTR_RST     = 32'h0000_0000;

	typedef enum logic [1:0] {
		ENT_AVAIL,
		ENT_ALLOC,
		ENT_VALID,
		ENT_ERROR
	} ent_state_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic [31:0] instr;
		logic        err;
		logic        ret;
	} mem_ret_t;

	typedef struct packed {
		logic rom;
		logic phys;
		logic sup;
	} space_t;

	typedef struct packed {
		ent_state_t [ENTRIES-1:0]                 st;
		logic [ENTRIES-1:0][31:0]                 word;
		logic [31:0]                              ptr;
		logic                                     alloc_pend;
		logic [1:0]                               alloc_idx;
		logic                                     stale;
		logic                                     req;
		logic [31:0]                              req_addr;
		logic                                     dec_valid;
		logic [31:0]                              dec_instr;
		logic                                     dec_cache;
		logic                                     trap;
		logic                                     co;
		logic                                     cd;
		logic                                     cd_eff;
		logic                                     inv_pend;
		logic [WAYS-1:0][LINES-1:0][ATAG_W-1:0]   tag;
		logic [WAYS-1:0][LINES-1:0][SPACE_W-1:0]  space;
		logic [WAYS-1:0][LINES-1:0][BLK_WORDS-1:0] vld;
		logic                                     cmode;
		logic                                     cway;
		logic [3:0]                               cline;
		logic [1:0]                               cword;
		logic                                     fmode;
		logic                                     fway;
		logic [3:0]                               fline;
		logic [2:0]                               fword;
		logic                                     rnd;
		logic [31:0]                              rdata;
	} state_t;
endpackage
`default_nettype wire

// ### instr_fetch_front.sv
// prefetch queue and branch target block store of the instruction front end
//
// Notes on behaviour
// - every queue entry is available, allocated, valid or error.
// - a permitted fetch allocates entry addr[3:2] and issues the external request.
// - a return fills its entry valid/error, or frees it when passed straight on.
// - an instruction waits in its entry until needed, then issues and frees it.
// - consuming an error entry frees it and raises the access trap.
// - at most one entry allocated, so one external fetch outstanding.
// - a non-sequential fetch frees all entries and stops the old stream.
// - no new-stream request before the leftover old instruction has returned.
// - needing an available entry starts a demand fetch from the program counter.
// - block store is two-way set-associative, 32-bit words, one instruction each.
// - blocks hold four words, or two when the block size bit is 1.
// - each block carries a 26-bit address tag and a 3-bit space tag.
// - a fill writes the space tag from rom, physical and supervisor bits.
// - four valid bits per block; invalidation clears all in one cycle.
// - plain invalidate clears the valid bits at the next branch.
// - disable bit 1 hides all entries from lookup but filling continues.
// - a disable change acts only after the next non-sequential fetch.
// - the line is chosen by bits 5-2 of the target address.
// - hit needs tag, translation, space match and disable 0 at previous non-sequential fetch.
// - a partial block still hits; only words with valid bit 1 are supplied.
// - lookup runs with translation; a hit gives decode word 0 next cycle.
// - with fetching on, request when entry ptr[3:2] is available and no fetch is allocated or stale.
// - a miss picks a clock-random way, clears its valid bits, sets them as stored.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`default_nettype none
module instr_fetch_front (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	// register port
	input  wire fetch_front_pkg::reg_req_t  reg_i,
	output logic [31:0]                     rdata_o,
	// execute stage controls
	input  wire logic                       fetch_en_i,
	input  wire logic                       nonseq_i,
	input  wire logic [31:0]                target_i,
	input  wire logic                       virt_i,
	input  wire logic                       xlat_ok_i,
	input  wire fetch_front_pkg::space_t    space_i,
	input  wire logic                       branch_i,
	input  wire logic                       invalidate_instr_i,
	input  wire logic                       return_and_invalidate_instr_i,
	// decode side
	input  wire logic                       need_i,
	input  wire logic [31:0]                program_counter_i,
	output logic                            dec_valid_o,
	output logic [31:0]                     dec_instr_o,
	output logic                            dec_cache_o,
	output logic                            trap_o,
	// external instruction memory
	output logic                            mreq_o,
	output logic [31:0]                     maddr_o,
	input  wire fetch_front_pkg::mem_ret_t  mem_i
);
	import fetch_front_pkg::*;

	state_t      r_reg;
	state_t      r_next;
	logic [31:0] cdata [WAYS][LINES*BLK_WORDS];
	logic        cw_en;
	logic        cw_way;
	logic [5:0]  cw_idx;
	logic [31:0] cw_data;
	logic [1:0]  hit_way;
	logic        hit;
	logic [2:0]  bsize;
	logic [3:0]  tline;
	logic [1:0]  pslot;
	logic [1:0]  islot;
	logic        served;
	logic        demand;

	////////////////////////////////////////////////////////////////////////
	// lookup of the non-sequential target
	assign tline = target_i[5:2];
	assign bsize = r_reg.co ? 3'(BLK_WORDS_CO) : 3'(BLK_WORDS);
	for (genvar w = 0; w < WAYS; w++) begin : g_way
		assign hit_way[w] = (r_reg.tag[w][tline] == target_i[31:6])
			&& (!virt_i || xlat_ok_i)
			&& (r_reg.space[w][tline] == space_i)
			&& !r_reg.cd_eff
			&& r_reg.vld[w][tline][0];
	end
	assign hit = |hit_way;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		r_next = r_reg;
		r_next.req = 1'b0;
		r_next.dec_valid = 1'b0;
		r_next.dec_cache = 1'b0;
		r_next.trap = 1'b0;
		r_next.rdata = 32'h0000_0000;
		r_next.rnd = ~r_reg.rnd;
		cw_en = 1'b0;
		cw_way = r_reg.fway;
		cw_idx = {r_reg.fline, r_reg.fword[1:0]};
		cw_data = 32'h0000_0000;
		served = 1'b0;
		demand = 1'b0;
		pslot = program_counter_i[3:2];

		// register port
		if (reg_i.wr && reg_i.addr == CFG_OFF) begin
			r_next.co = reg_i.wdata[CFG_CO_BIT];
			r_next.cd = reg_i.wdata[CFG_CD_BIT];
		end
		if (reg_i.rd) begin
			case (reg_i.addr)
				CFG_OFF:  r_next.rdata = {30'h0, r_reg.cd, r_reg.co};
				STAT_OFF: r_next.rdata = {18'h0, r_reg.fmode, r_reg.cmode, r_reg.inv_pend,
					r_reg.cd_eff, r_reg.stale, r_reg.alloc_pend, r_reg.st};
				default:  r_next.rdata = 32'h0000_0000;
			endcase
		end

		// word from cache block, while streaming a hit
		if (need_i && !nonseq_i && r_reg.cmode) begin
			if ({1'b0, r_reg.cword} < bsize && r_reg.vld[r_reg.cway][r_reg.cline][r_reg.cword]) begin
				r_next.dec_valid = 1'b1;
				r_next.dec_cache = 1'b1;
				r_next.dec_instr = cdata[r_reg.cway][{r_reg.cline, r_reg.cword}];
				r_next.cword = r_reg.cword + 2'h1;
				served = 1'b1;
			end else begin
				r_next.cmode = 1'b0;
			end
		end

		// memory return
		if (mem_i.ret) begin
			if (r_reg.stale) begin
				r_next.stale = 1'b0;
			end else if (r_reg.alloc_pend) begin
				r_next.alloc_pend = 1'b0;
				if (need_i && !nonseq_i && !served && pslot == r_reg.alloc_idx) begin
					r_next.st[r_reg.alloc_idx] = ENT_AVAIL;
					r_next.dec_valid = 1'b1;
					r_next.dec_instr = mem_i.instr;
					r_next.trap = mem_i.err;
					served = 1'b1;
				end else begin
					r_next.word[r_reg.alloc_idx] = mem_i.instr;
					r_next.st[r_reg.alloc_idx] = mem_i.err ? ENT_ERROR : ENT_VALID;
				end
			end
		end

		// consumption from the queue
		if (need_i && !nonseq_i && !served && !r_next.cmode) begin
			case (r_reg.st[pslot])
				ENT_VALID: begin
					r_next.st[pslot] = ENT_AVAIL;
					r_next.dec_valid = 1'b1;
					r_next.dec_instr = r_reg.word[pslot];
					served = 1'b1;
				end
				ENT_ERROR: begin
					r_next.st[pslot] = ENT_AVAIL;
					r_next.dec_valid = 1'b1;
					r_next.dec_instr = r_reg.word[pslot];
					r_next.trap = 1'b1;
					served = 1'b1;
				end
				ENT_AVAIL: begin
					// a demand fetch goes out even while prefetching is off
					r_next.ptr = program_counter_i;
					demand = 1'b1;
				end
				default:   r_next.ptr = r_next.ptr;
			endcase
		end

		// fill of the victim block as words go to decode
		if (served && !r_next.dec_cache && !r_next.trap && r_reg.fmode) begin
			cw_en = 1'b1;
			cw_data = r_next.dec_instr;
			r_next.vld[r_reg.fway][r_reg.fline][r_reg.fword[1:0]] = 1'b1;
			r_next.fword = r_reg.fword + 3'h1;
			if (r_reg.fword + 3'h1 >= bsize) begin
				r_next.fmode = 1'b0;
			end
		end

		// invalidation
		if (branch_i && r_reg.inv_pend) begin
			r_next.vld = '0;
			r_next.inv_pend = 1'b0;
		end
		// a new invalidate beside the clearing branch stays pending
		if (invalidate_instr_i) begin
			r_next.inv_pend = 1'b1;
		end
		if (return_and_invalidate_instr_i) begin
			r_next.vld = '0;
		end

		// non-sequential fetch
		if (nonseq_i) begin
			for (int e = 0; e < ENTRIES; e++) begin
				r_next.st[e] = ENT_AVAIL;
			end
			if (r_reg.alloc_pend && !mem_i.ret) begin
				r_next.stale = 1'b1;
			end
			r_next.alloc_pend = 1'b0;
			r_next.cd_eff = r_reg.cd;
			r_next.cmode = 1'b0;
			r_next.fmode = 1'b0;
			if (hit) begin
				r_next.cway = hit_way[1];
				r_next.cline = tline;
				r_next.cword = 2'h1;
				r_next.cmode = 1'b1;
				r_next.dec_valid = 1'b1;
				r_next.dec_cache = 1'b1;
				r_next.dec_instr = cdata[hit_way[1]][{tline, 2'h0}];
				r_next.ptr = target_i + {27'h0, bsize, 2'h0};
			end else begin
				r_next.fway = r_reg.rnd;
				r_next.fline = tline;
				r_next.fword = 3'h0;
				r_next.fmode = 1'b1;
				r_next.vld[r_reg.rnd][tline] = '0;
				r_next.tag[r_reg.rnd][tline] = target_i[31:6];
				r_next.space[r_reg.rnd][tline] = space_i;
				r_next.ptr = target_i;
			end
		end

		// request issue
		islot = r_next.ptr[3:2];
		if ((fetch_en_i || demand) && !nonseq_i && !r_next.alloc_pend && !r_next.stale
			&& r_next.st[islot] == ENT_AVAIL) begin
			r_next.st[islot] = ENT_ALLOC;
			r_next.alloc_pend = 1'b1;
			r_next.alloc_idx = islot;
			r_next.req = 1'b1;
			r_next.req_addr = r_next.ptr;
			r_next.ptr = r_next.ptr + 32'h0000_0004;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r_reg <= '0;
			r_reg.co <= CFG_RST[CFG_CO_BIT];
			r_reg.cd <= CFG_RST[CFG_CD_BIT];
			r_reg.ptr <= PTR_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (cw_en) begin
			cdata[cw_way][cw_idx] <= cw_data;
		end
	end

	assign rdata_o     = r_reg.rdata;
	assign dec_valid_o = r_reg.dec_valid;
	assign dec_instr_o = r_reg.dec_instr;
	assign dec_cache_o = r_reg.dec_cache;
	assign trap_o      = r_reg.trap;
	assign mreq_o      = r_reg.req;
	assign maddr_o     = r_reg.req_addr;

	////////////////////////////////////////////////////////////////////////
	// checks
	logic [2:0] n_alloc;
	always_comb begin
		n_alloc = 3'h0;
		for (int e = 0; e < ENTRIES; e++) begin
			n_alloc = n_alloc + 3'(r_reg.st[e] == ENT_ALLOC);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	one_alloc_a: assert property (n_alloc <= 3'h1 && (n_alloc == 3'h1) == r_reg.alloc_pend)
		else $error("more than one allocated entry");
	req_alloc_a: assert property (mreq_o |-> r_reg.st[maddr_o[3:2]] == ENT_ALLOC)
		else $error("request without allocated entry");
	stale_block_a: assert property (r_reg.stale && !mem_i.ret |=> !mreq_o && r_reg.stale)
		else $error("new stream request before leftover return");
	nonseq_free_a: assert property (nonseq_i |=> !r_reg.alloc_pend && !mreq_o && !trap_o)
		else $error("old stream survived non-sequential fetch");
	error_trap_a: assert property (need_i && !nonseq_i && !r_reg.cmode && !mem_i.ret
		&& r_reg.st[program_counter_i[3:2]] == ENT_ERROR |=> trap_o && dec_valid_o)
		else $error("error entry consumed without trap");
	valid_issue_a: assert property (need_i && !nonseq_i && !r_reg.cmode && !mem_i.ret
		&& r_reg.st[program_counter_i[3:2]] == ENT_VALID
		|=> dec_valid_o && !trap_o && dec_instr_o == $past(r_reg.word[program_counter_i[3:2]]))
		else $error("valid entry not issued");
	hit_next_a: assert property (nonseq_i && hit |=> dec_valid_o && dec_cache_o)
		else $error("hit not presented next cycle");
	disable_a: assert property (nonseq_i && r_reg.cd_eff |=> !dec_cache_o)
		else $error("hit while store disabled");
	return_and_invalidate_instr_a: assert property (return_and_invalidate_instr_i |=> r_reg.vld == '0)
		else $error("valid bits not cleared");
	reset_state_a: assert property (disable iff (1'b0) sys_rst_i |=> !mreq_o && !r_reg.alloc_pend
		&& r_reg.st == '0)
		else $error("entries not free after reset");

	hit_c: cover property (nonseq_i && hit ##1 dec_cache_o);
	trap_c: cover property (trap_o);
	stale_c: cover property (r_reg.stale ##[1:8] !r_reg.stale ##[1:8] mreq_o);
	demand_c: cover property (need_i && r_reg.st[program_counter_i[3:2]] == ENT_AVAIL ##1 mreq_o);
endmodule
`default_nettype wire

// ### instr_mem_model.sv
// behavioural external instruction memory answering one fetch at a time
`default_nettype none
module instr_mem_model (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	// fetch request from the front end
	input  wire logic                      mreq_i,
	input  wire logic [31:0]               maddr_i,
	// answer shaping from the bench
	input  wire logic [3:0]                delay_i,
	input  wire logic [31:0]               err_addr_i,
	output var  fetch_front_pkg::mem_ret_t mem_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import fetch_front_pkg::*;
	logic        pend;
	logic [3:0]  cnt;
	logic [31:0] addr;

	////////////////////////////////////////////////////////////////
	// an old-stream word is still returned, but only the one pending
	always_ff @(posedge clk_i) begin
		mem_o.ret <= 1'b0;
		// released data lines toggle so stale words never look held
		mem_o.instr <= ~mem_o.instr;
		if (sys_rst_i) begin
			pend <= 1'b0;
			mem_o <= '0;
		end else begin
			if (pend && cnt <= 4'h1) begin
				mem_o <= '{instr: ~addr, err: addr == err_addr_i, ret: 1'b1};
				pend <= 1'b0;
			end else if (pend) begin
				cnt <= cnt - 4'h1;
			end
			if (mreq_i) begin
				pend <= 1'b1;
				addr <= maddr_i;
				cnt <= delay_i;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb_instr_fetch_front.sv
// self-checking bench for the instruction fetch front end
`default_nettype none
module tb_instr_fetch_front;
	timeunit 1ns;
	timeprecision 1ps;
	import fetch_front_pkg::*;
	logic clk, rst, fetch_en, nonseq, virt, xlat, branch, invalidate_instr, rinv, need;
	logic dv, dc, trap, mreq, out;
	logic [31:0] rdata, target, pc, di, maddr, err_addr;
	logic [3:0] delay;
	reg_req_t rq;
	space_t space;
	mem_ret_t mem;
	int mismatches, n_checks, cyc;

	instr_fetch_front u_dut (.clk_i(clk), .sys_rst_i(rst), .reg_i(rq), .rdata_o(rdata),
		.fetch_en_i(fetch_en), .nonseq_i(nonseq), .target_i(target), .virt_i(virt),
		.xlat_ok_i(xlat), .space_i(space), .branch_i(branch), .invalidate_instr_i(invalidate_instr),
		.return_and_invalidate_instr_i(rinv), .need_i(need), .program_counter_i(pc),
		.dec_valid_o(dv), .dec_instr_o(di), .dec_cache_o(dc), .trap_o(trap),
		.mreq_o(mreq), .maddr_o(maddr), .mem_i(mem));
	instr_mem_model u_mem (.clk_i(clk), .sys_rst_i(rst), .mreq_i(mreq), .maddr_i(maddr),
		.delay_i(delay), .err_addr_i(err_addr), .mem_o(mem));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// a request must never be issued while another is still unanswered
	always @(posedge clk) begin
		if (!rst && mreq)
			chk("single outstanding", 32'h0, {31'h0, out});
		if (rst || mem.ret)
			out <= 1'b0;
		if (mreq)
			out <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic wr_reg(logic [3:0] a, logic [31:0] d);
		@(posedge clk) rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) rq <= '0;
	endtask

	task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
		@(posedge clk) rq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk) rq <= '0;
		#1 d = rdata;
	endtask

	// requests are never adjacent, so one cycle is skipped after capture
	task automatic wait_req(output logic [31:0] a);
		for (int i = 0; i < 80 && mreq !== 1'b1; i++)
			@(posedge clk) #1;
		chk("request seen", 32'h1, {31'h0, mreq});
		a = maddr;
		@(posedge clk) #1;
	endtask

	task automatic take(logic [31:0] p, logic et, logic ec);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk) need <= 1'b1;
			pc <= p;
			@(posedge clk) need <= 1'b0;
			#1 if (dv === 1'b1)
				break;
		end
		chk("decode valid", 32'h1, {31'h0, dv});
		chk("decode word", ~p, di);
		chk("trap", {31'h0, et}, {31'h0, trap});
		chk("from store", {31'h0, ec}, {31'h0, dc});
	endtask

	task automatic jump(logic [31:0] t, logic hit);
		@(posedge clk) nonseq <= 1'b1;
		target <= t;
		@(posedge clk) nonseq <= 1'b0;
		#1 chk("hit", {31'h0, hit}, {31'h0, dc});
		if (hit)
			chk("hit word", ~t, di);
	endtask

	task automatic fill(logic [31:0] t);
		jump(t, 1'b0);
		for (int i = 0; i < 4; i++)
			take(t + 32'(4 * i), 1'b0, 1'b0);
	endtask

	// k selects the strobe: 0 branch, 1 plain invalidate, 2 immediate invalidate
	task automatic pulse(logic [1:0] k);
		@(posedge clk) {branch, invalidate_instr, rinv} <= {k == 2'h0, k == 2'h1, k == 2'h2};
		@(posedge clk) {branch, invalidate_instr, rinv} <= 3'h0;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_start();
		logic [31:0] d;
		rd_reg(STAT_OFF, d);
		chk("idle status", 32'h0, d);
		fetch_en <= 1'b1;
		wait_req(d);
		chk("first address", 32'h0, d);
		repeat (3) wait_req(d);
		repeat (4) @(posedge clk);
		rd_reg(STAT_OFF, d);
		chk("full queue", 32'h0aa, {23'h0, d[8:0]});
	endtask

	task automatic t_consume();
		logic [31:0] d;
		take(32'h0, 1'b0, 1'b0);
		wait_req(d);
		chk("refill address", 32'h10, d);
		for (int i = 1; i < 4; i++)
			take(32'(4 * i), 1'b0, 1'b0);
		take(32'h10, 1'b1, 1'b0);
	endtask

	task automatic t_switch();
		logic [31:0] d;
		delay <= 4'h6;
		wait_req(d);
		jump(32'h800, 1'b0);
		take(32'h800, 1'b0, 1'b0);
		delay <= 4'h2;
	endtask

	task automatic t_cache();
		fill(32'h1000);
		jump(32'h1000, 1'b1);
		take(32'h1004, 1'b0, 1'b1);
		space <= space_t'(3'h4);
		jump(32'h1000, 1'b0);
		space <= space_t'(3'h0);
		fill(32'h1104);
		virt <= 1'b1;
		xlat <= 1'b0;
		jump(32'h1104, 1'b0);
		virt <= 1'b0;
		xlat <= 1'b1;
		fill(32'h1208);
		wr_reg(CFG_OFF, 32'h2);
		jump(32'h1208, 1'b1);
		jump(32'h1208, 1'b0);
		wr_reg(CFG_OFF, 32'h0);
		jump(32'h1208, 1'b0);
		fill(32'h130c);
		pulse(2'h1);
		jump(32'h130c, 1'b1);
		pulse(2'h0);
		jump(32'h130c, 1'b0);
		fill(32'h1410);
		pulse(2'h2);
		jump(32'h1410, 1'b0);
	endtask

	task automatic t_misc();
		logic [31:0] d;
		fetch_en <= 1'b0;
		jump(32'h300, 1'b0);
		take(32'h30c, 1'b0, 1'b0);
		fetch_en <= 1'b1;
		wr_reg(CFG_OFF, 32'h1);
		rd_reg(CFG_OFF, d);
		chk("block size select", 32'h1, d);
		fill(32'h1500);
		jump(32'h1500, 1'b1);
		take(32'h1504, 1'b0, 1'b1);
		take(32'h1508, 1'b0, 1'b0);
		rd_reg(4'h8, d);
		chk("unmapped read", 32'h0, d);
		wr_reg(CFG_OFF, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		rq = '0;
		{fetch_en, nonseq, virt, branch, invalidate_instr, rinv, need} = '0;
		xlat = 1'b1;
		space = '0;
		target = '0;
		pc = '0;
		delay = 4'h2;
		err_addr = 32'h10;
		mismatches = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_start();
		t_consume();
		t_switch();
		t_cache();
		t_misc();
		finish_test();
	end
endmodule
`default_nettype wire
